// ### design/ddc_channel_config.sv
// Purpose: configuration and data path steering of one down-converter channel
// Assumes: samples synchronous to pclk; APB slave with zero wait states
// Notes: filter stages themselves are outside; this selects, routes and decimates
// Behaviour
// - mixer bit 0 real mixer from one channel, 1 complex from two
// - gain bit 1 doubles output, 0 passes unchanged
// - complex-to-real bit 1 drives only I output, 0 both valid
// - code 000: stages one, two; rate 2 or 4
// - code 001: stages one to three; rate 4 or 8
// - code 010: stages one to four; rate 8 or 16
// - code 011: stage one only; rate 1 or 2
// - code 100: stage one plus third-band; rate 3 or 6
// - code 101: stages one, two plus third-band; rate 6 or 12
// - code 110: stages one to three plus third-band; rate 12 or 24
// - code 111 hands choice to the extended field
// - extended field ignored unless main code is all ones
// - extended 0: third-band and all four half-bands; rate 48 or 24
// - extended 2: fifth-band plus stage one; rate 10 or 5
// - extended 3: fifth-band plus stages one, two; rate 20 or 10
// - extended 4: fifth-band plus stages one to three; rate 40 or 20
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ddc_channel_config import ddc_channel_pkg::*; (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter samples
    input wire logic [sample_w-1:0] chan_a,
    input wire logic [sample_w-1:0] chan_b,
    input wire logic sample_valid,
    // output to framing
    output logic [sample_w-1:0] out_i,
    output logic [sample_w-1:0] out_q,
    output logic out_i_valid,
    output logic out_q_valid,
    // decoded configuration
    output logic [stage_w-1:0] stage_enable,
    output logic [5:0] decim_ratio,
    output logic [1:0] if_mode,
    output logic complex_mixer,
    output logic config_error
);
    logic [7:0] control;
    logic [7:0] input_select;
    logic [stage_w-1:0] next_stage;
    logic [5:0] next_ratio;
    logic next_error;
    logic strobe;
    logic [sample_w-1:0] mix_i;
    logic [sample_w-1:0] mix_q;
    logic fs_flip;
    logic c2r;

    // half rate when complex-to-real drops the Q path
    function automatic logic [5:0] pick_rate(input logic on, input logic [5:0] r_on,
                                             input logic [5:0] r_off);
        return on ? r_on : r_off;
    endfunction : pick_rate

    function automatic logic [sample_w-1:0] apply_gain(input logic [sample_w-1:0] s,
                                                       input logic g);
        return g ? {s[sample_w-2:0], 1'b0} : s;
    endfunction : apply_gain

    assign c2r = control[bit_c2r];
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire mapped = (paddr == addr_control) || (paddr == addr_input_select);

    // register writes on the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= control_reset;
        end else if (wr && paddr == addr_control) begin
            control <= pwdata[reg_w-1:0];
        end
    end

    // reserved bits of the select register stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_select <= input_select_reset;
        end else if (wr && paddr == addr_input_select) begin
            input_select <= pwdata[reg_w-1:0] & input_select_mask;
        end
    end

    // read multiplexer, unmapped reads as zero
    function automatic logic [reg_w-1:0] read_reg(input logic [11:0] a);
        if (a == addr_control) begin
            return control;
        end else if (a == addr_input_select) begin
            return input_select;
        end else begin
            return 8'h00;
        end
    endfunction : read_reg

    // ready answers every setup cycle: one wait-free access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // unmapped addresses are refused; writes to them are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !mapped;
        end
    end

    // read data taken in the setup cycle, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, read_reg(paddr)};
        end
    end

    // decode filter chain selection
    always_comb begin
        next_stage = 6'h00;
        next_ratio = 6'h01;
        next_error = 1'b0;
        case (control[dec_hi:dec_lo])
            3'h0: begin
                next_stage = 6'h03;
                next_ratio = pick_rate(c2r, 6'h02, 6'h04);
            end
            3'h1: begin
                next_stage = 6'h07;
                next_ratio = pick_rate(c2r, 6'h04, 6'h08);
            end
            3'h2: begin
                next_stage = 6'h0F;
                next_ratio = pick_rate(c2r, 6'h08, 6'h10);
            end
            3'h3: begin
                next_stage = 6'h01;
                next_ratio = pick_rate(c2r, 6'h01, 6'h02);
            end
            3'h4: begin
                next_stage = 6'h11;
                next_ratio = pick_rate(c2r, 6'h03, 6'h06);
            end
            3'h5: begin
                next_stage = 6'h13;
                next_ratio = pick_rate(c2r, 6'h06, 6'h0C);
            end
            3'h6: begin
                next_stage = 6'h17;
                next_ratio = pick_rate(c2r, 6'h0C, 6'h18);
            end
            default: begin
                case (input_select[ext_hi:ext_lo])
                    4'h0: begin
                        next_stage = 6'h1F;
                        next_ratio = pick_rate(c2r, 6'h18, 6'h30);
                    end
                    4'h2: begin
                        next_stage = 6'h21;
                        next_ratio = pick_rate(c2r, 6'h05, 6'h0A);
                    end
                    4'h3: begin
                        next_stage = 6'h23;
                        next_ratio = pick_rate(c2r, 6'h0A, 6'h14);
                    end
                    4'h4: begin
                        next_stage = 6'h27;
                        next_ratio = pick_rate(c2r, 6'h14, 6'h28);
                    end
                    default: begin
                        next_error = 1'b1;
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_enable <= '0;
        end else begin
            stage_enable <= next_stage;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decim_ratio <= ratio_reset;
        end else begin
            decim_ratio <= next_ratio;
        end
    end

    // reserved extended codes raise the error and mute the outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_error <= 1'b0;
        end else begin
            config_error <= next_error;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if_mode <= 2'h0;
        end else begin
            if_mode <= control[bit_if_hi:bit_if_lo];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            complex_mixer <= 1'b0;
        end else begin
            complex_mixer <= control[bit_mixer];
        end
    end

    always_comb begin
        mix_i = input_select[bit_i_sel] ? chan_b : chan_a;
        // real mixer uses I channel for both
        mix_q = control[bit_mixer] ? (input_select[bit_q_sel] ? chan_b : chan_a) : mix_i;
    end

    ddc_decim_counter decimator (
        .pclk(pclk),
        .presetn(presetn),
        .ratio(decim_ratio),
        .in_valid(sample_valid),
        .strobe(strobe)
    );

    // fs mixing flips sign each output in complex-to-real mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_flip <= 1'b0;
        end else if (strobe && c2r) begin
            fs_flip <= !fs_flip;
        end else if (!c2r) begin
            fs_flip <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_i_valid <= 1'b0;
        end else begin
            out_i_valid <= strobe && !next_error;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q_valid <= 1'b0;
        end else begin
            out_q_valid <= strobe && !next_error && !c2r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_i <= '0;
        end else if (strobe) begin
            out_i <= apply_gain(fs_flip ? (~mix_i + 16'h0001) : mix_i, control[bit_gain]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else if (strobe) begin
            out_q <= c2r ? '0 : apply_gain(mix_q, control[bit_gain]);
        end
    end
endmodule : ddc_channel_config
`default_nettype wire

// ### design/ddc_channel_pkg.sv
// Purpose: constants for one down-converter channel configuration block
// Assumes: 25 MHz pclk, 16-bit converter samples
// Notes: registers are numbered by index; each takes one aligned word on APB
package ddc_channel_pkg;
    localparam logic [11:0] index_control = 12'h350;
    localparam logic [11:0] index_input_select = 12'h351;
    // byte address is four times the index
    localparam logic [11:0] addr_control = {index_control[9:0], 2'b00};
    localparam logic [11:0] addr_input_select = {index_input_select[9:0], 2'b00};
    localparam int reg_w = 8;
    localparam int dec_hi = 2;
    localparam int dec_lo = 0;
    localparam logic [5:0] ratio_reset = 6'h01;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] input_select_reset = 8'h00;
    localparam int bit_mixer = 7;
    localparam int bit_gain = 6;
    localparam int bit_if_hi = 5;
    localparam int bit_if_lo = 4;
    localparam int bit_c2r = 3;
    localparam int bit_q_sel = 2;
    localparam int bit_i_sel = 0;
    localparam int ext_hi = 7;
    localparam int ext_lo = 4;
    localparam logic [7:0] input_select_mask = 8'hF5;
    localparam int sample_w = 16;
    localparam logic [2:0] dec_use_ext = 3'h7;
    // stage enable bits, high to low: fifth-band, third-band, half-band four down to one
    localparam int stage_w = 6;
    typedef enum {if_variable, if_zero, if_fs, if_test} if_mode_t;
endpackage : ddc_channel_pkg

// ### design/ddc_decim_counter.sv
// Purpose: emits one output strobe every ratio input samples
// Assumes: ratio at least one
// Notes: restarts when ratio changes
`timescale 1ns/10ps
`default_nettype none
module ddc_decim_counter import ddc_channel_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [5:0] ratio,
    input wire logic in_valid,
    output logic strobe
);
    logic [5:0] count;
    logic [5:0] last_ratio;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 6'h00;
            last_ratio <= 6'h00;
        end else begin
            last_ratio <= ratio;
            if (ratio != last_ratio) begin
                count <= 6'h00;
            end else if (in_valid) begin
                count <= (count + 6'h01 >= ratio) ? 6'h00 : count + 6'h01;
            end
        end
    end

    assign strobe = in_valid && (ratio == last_ratio) && (count + 6'h01 >= ratio);
endmodule : ddc_decim_counter
`default_nettype wire

// ### tb/ddc_cfg_sva.sv
// Purpose: port checks of the channel configuration block
// Assumes: zero wait APB, decode one edge after a write
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module ddc_cfg_chk import ddc_channel_pkg::*; (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // decode
    input wire logic out_i_valid,
    input wire logic [stage_w-1:0] stage_enable,
    input wire logic [5:0] decim_ratio,
    input wire logic complex_mixer,
    input wire logic config_error
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic hit;
    assign hit = paddr == addr_control || paddr == addr_input_select;
    a_ready_after: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
    a_bad_addr: assert property (pready && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    a_good_addr: assert property (pready && hit |-> !pslverr) else $error("mapped refused");
    a_mixer_follow: assert property (
        pready && pwrite && paddr == addr_control |=> ##1
        complex_mixer == $past(pwdata[bit_mixer], 2)) else $error("mixer stale");
    a_stage_one_ratio: assert property (
        stage_enable == 6'h01 && !config_error |-> decim_ratio inside {6'h01, 6'h02})
        else $error("bad ratio");
    a_fifth_ratio: assert property (
        stage_enable == 6'h21 && !config_error |-> decim_ratio inside {6'h05, 6'h0A})
        else $error("bad ratio");
    a_err_quiet: assert property (
        config_error && $past(config_error, 3) |-> !out_i_valid) else $error("output on error");
    c_refused: cover property (pready && pslverr);
    c_reserved: cover property (config_error);
    c_output: cover property (out_i_valid && complex_mixer);
endmodule : ddc_cfg_chk
bind ddc_channel_config ddc_cfg_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_i_valid(out_i_valid),
    .stage_enable(stage_enable), .decim_ratio(decim_ratio), .complex_mixer(complex_mixer),
    .config_error(config_error));
`default_nettype wire

// ### tb/ddc_adc_model.sv
// Purpose: converter channel model feeding samples
// Assumes: bench sets the sample values
// Notes: slow gives a sample every other cycle
`timescale 1ns/10ps
`default_nettype none
module ddc_adc_model import ddc_channel_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic slow,
    input wire logic [sample_w-1:0] a_val,
    input wire logic [sample_w-1:0] b_val,
    // samples
    output logic [sample_w-1:0] chan_a,
    output logic [sample_w-1:0] chan_b,
    output logic sample_valid
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= !slow || !sample_valid;
        end
    end
    // lines carry the inverse between samples
    assign chan_a = sample_valid ? a_val : ~a_val;
    assign chan_b = sample_valid ? b_val : ~b_val;
endmodule : ddc_adc_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench of the channel configuration block
// Assumes: samples held steady during each data check
// Notes: expected decode comes from the tables
`timescale 1ns/10ps
`default_nettype none
module tb import ddc_channel_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic slow = 1'b0, err;
    logic [3:0] e;
    logic [11:0] paddr = 12'h000;
    logic [15:0] a_val = 16'h0000, b_val = 16'h0000, eq;
    logic [31:0] pwdata = 32'h0, rd, r, seed = 32'h2299;
    wire logic [31:0] prdata;
    wire logic [15:0] chan_a, chan_b, out_i, out_q;
    wire logic [5:0] stage_enable, decim_ratio;
    wire logic [1:0] if_mode;
    wire logic pready, pslverr, sample_valid, out_i_valid, out_q_valid;
    wire logic complex_mixer, config_error;
    int fails = 0, samples_checked = 0;
    localparam logic [5:0] st_tab [11] = '{6'h03, 6'h07, 6'h0F, 6'h01, 6'h11, 6'h13,
        6'h17, 6'h1F, 6'h21, 6'h23, 6'h27};
    localparam logic [5:0] rt_tab [11] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C,
        6'h18, 6'h30, 6'h0A, 6'h14, 6'h28};
    ddc_channel_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a(chan_a), .chan_b(chan_b), .sample_valid(sample_valid),
        .out_i(out_i), .out_q(out_q), .out_i_valid(out_i_valid), .out_q_valid(out_q_valid),
        .stage_enable(stage_enable), .decim_ratio(decim_ratio), .if_mode(if_mode),
        .complex_mixer(complex_mixer), .config_error(config_error));
    ddc_adc_model adc (.pclk(pclk), .presetn(presetn), .slow(slow), .a_val(a_val),
        .b_val(b_val), .chan_a(chan_a), .chan_b(chan_b), .sample_valid(sample_valid));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [11:0] dec(input int i, input logic c);
        return {st_tab[i], c ? rt_tab[i] >> 1 : rt_tab[i]};
    endfunction : dec
    function automatic logic [15:0] pick(input logic b, input logic g);
        return (b ? b_val : a_val) << g;
    endfunction : pick
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_for(input logic on_out);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((on_out ? out_i_valid : pready) !== 1'b1 && n < 100);
        if ((on_out ? out_i_valid : pready) !== 1'b1) begin
            fails++;
            test_done();
        end
    endtask : wait_for
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_for(1'b0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'({stage_enable, decim_ratio}), 32'(dec(0, 1'b0)));
        apb(1'b0, addr_control, 32'h0);
        chk(rd, 32'(control_reset));
        apb(1'b1, 12'h352, 32'hFF);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h352, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 22; i++) begin
            r = rnd();
            e = i < 14 ? r[7:4] : i < 16 ? 4'h0 : 4'(i / 2 - 6);
            apb(1'b1, addr_input_select, {24'h0, e, r[3:0]});
            apb(1'b0, addr_input_select, 32'h0);
            chk(rd, {24'h0, e, r[3:0] & 4'h5});
            apb(1'b1, addr_control, {24'h0, r[15:12], i[0], i < 14 ? 3'(i / 2) : 3'h7});
            repeat (3) @(posedge pclk);
            chk(32'({stage_enable, decim_ratio}), 32'(dec(i / 2, i[0])));
            chk(32'({complex_mixer, if_mode}), 32'({r[15], r[13:12]}));
        end
        apb(1'b1, addr_input_select, 32'h10);
        apb(1'b1, addr_control, 32'h07);
        repeat (3) @(posedge pclk);
        chk(32'(config_error), 32'h1);
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            a_val <= r[15:0];
            b_val <= r[31:16];
            slow <= r[5];
            apb(1'b1, addr_input_select, {29'h0, r[9], 1'b0, r[8]});
            apb(1'b1, addr_control, {24'h0, r[11:10], k == 5 ? 6'h0B : 6'h03});
            repeat (8) @(posedge pclk);
            wait_for(1'b1);
            eq = k == 5 ? 16'h0 : r[11] ? pick(r[9], r[10]) : pick(r[8], r[10]);
            if (k < 5) chk(32'(out_i), 32'(pick(r[8], r[10])));
            chk(32'(out_q), 32'(eq));
            chk(32'(out_q_valid), 32'(k != 5));
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
